// ===== csd_pkg.sv
// csd_pkg: register map, field layout and reset values of the chip-select decoder
// assumes a 32-bit avalon-mm slave with word addressing (index = byte address / 4)
package csd_pkg;

  // register word indices
  localparam logic [3:0] CSD_IDX_BASE0   = 4'h0; // select0_base_match .. select3 at +1..+3
  localparam logic [3:0] CSD_IDX_OPT0    = 4'h4; // select0_options .. select3 at +1..+3
  localparam logic [3:0] CSD_IDX_CTRL    = 4'h8; // system_control_word enables
  localparam logic [3:0] CSD_IDX_STATUS  = 4'h9; // sticky event flags, write one to clear

  localparam int CSD_UNITS = 4;

  // base register fields
  localparam int CSD_BR_FC_HI   = 15;
  localparam int CSD_BR_FC_LO   = 13;
  localparam int CSD_BR_ADDR_HI = 12;
  localparam int CSD_BR_ADDR_LO = 2;
  localparam int CSD_BR_RW      = 1;
  localparam int CSD_BR_EN      = 0;

  // option register fields
  localparam int CSD_OR_WS_HI   = 15;
  localparam int CSD_OR_WS_LO   = 13;
  localparam int CSD_OR_MASK_HI = 12;
  localparam int CSD_OR_MASK_LO = 2;
  localparam int CSD_OR_MRW     = 1;
  localparam int CSD_OR_CFC     = 0;

  // control and status bit positions
  localparam int CSD_CTRL_WRITE_PROTECT_ERROR_ENABLE  = 0; // write_protect_error_enable
  localparam int CSD_CTRL_DECODE_CONFLICT_ERROR_ENABLE  = 1; // decode_conflict_error_enable
  localparam int CSD_CTRL_EXTERNAL_MASTER_EXTRA_WAIT  = 2; // external_master_extra_wait
  localparam int CSD_STAT_WPV   = 0; // write_protect_flag
  localparam int CSD_STAT_ADC   = 1; // decode conflict flag

  // reset values
  localparam logic [15:0] CSD_BR0_RST  = 16'hc001; // fc 110, base 0, read, enabled
  localparam logic [15:0] CSD_BRN_RST  = 16'hc000; // fc 110, base 0, read, disabled
  localparam logic [15:0] CSD_OR_RST   = 16'hdffd; // 6 waits, mask ones, mrw 0, cfc 1
  localparam logic [2:0]  CSD_CTRL_RST = 3'h0;
  localparam logic [1:0]  CSD_STAT_RST = 2'h0;

  // encodings
  localparam logic [2:0] CSD_WS_EXTERNAL = 3'h7;
  localparam logic [2:0] CSD_FC_RESERVED = 3'h7;
  localparam logic [3:0] CSD_CNT_MAX     = 4'h8;

endpackage : csd_pkg

// ===== csd_top.sv
// csd_top: four chip-select units, wait-state acknowledge and error flags, avalon-mm registers
// assumes bus-cycle inputs are synchronous to MCLK and stable while the address strobe is low
//
// Notes on behaviour
// - four identical units, each with writable 16-bit base and option registers
// - base bits 15-13 hold space code; 111 means the line never asserts
// - reset loads space code 110 into every base register
// - only bus address bits 23-13 compare against base bits 12-2
// - reset clears base addresses; only select line 0 can then assert
// - base direction bit 0 reads only, 1 writes only; resets to 0
// - direction check bit 0 matches both directions, 1 honours direction; resets 0
// - write to checked read-only unit sets write-protect flag, bus error if enabled
// - enable bit 0 disables the line; after reset only unit 0 enabled
// - registers may change while the unit is enabled
// - option bits 15-13 give zero to six wait states before acknowledge
// - wait field 111 suppresses internal acknowledge; external acknowledge ends cycle
// - reset loads six wait states into every option register
// - wait states count on MCLK, also for external masters
// - zero wait states give acknowledge combinationally from the match, unless the external-master extra wait adds one
// - mask bit 0 makes the address bit don't-care, 1 compares it
// - reset loads all mask bits with ones, the 8k block
// - compare bit 0 ignores space code, 1 compares it; resets to 1
// - bus space code 111 never asserts any select line
// - several matches drive only the highest priority line, unit 0 first
// - multiple matches set conflict flag, bus error if enabled
// - internal memory and register accesses assert no select line
// - interrupt acknowledge cycles never match
`timescale 1ns/10ps
module csd_top
  import csd_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  // avalon-mm register slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // processor bus cycle
  input  wire logic        ADDRESS_STROBE_N,
  input  wire logic [23:13] BUS_ADDR,
  input  wire logic [2:0]  SPACE_CODE,
  input  wire logic        BUS_WRITE,
  input  wire logic        INTERNAL_ACCESS,
  input  wire logic        INT_ACK_CYCLE,
  input  wire logic        EXTERNAL_MASTER,
  // outputs to memories and bus master
  output logic      [3:0]  SELECT_N,
  output logic             TRANSFER_ACK_N_O,
  output logic             TRANSFER_ACK_OE,
  output logic             BUS_ERROR_N_O,
  output logic             BUS_ERROR_OE
);

  logic [15:0] base_q [CSD_UNITS];
  logic [15:0] base_d [CSD_UNITS];
  logic [15:0] opt_q  [CSD_UNITS];
  logic [15:0] opt_d  [CSD_UNITS];
  logic [2:0]  ctrl_q, ctrl_d;
  logic [1:0]  stat_q, stat_d;
  logic        done_q, done_d;
  logic [31:0] rdata_q, rdata_d;
  logic        req, wr_take;
  logic [15:0] wmask;

  logic        strobe;
  logic        strobe_q, strobe_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [3:0]  sel_q, sel_d;
  logic [3:0]  hit;       // address, space code and enable match
  logic [3:0]  full;      // hit that also passes the direction check
  logic [3:0]  viol;      // hit refused by write protection
  logic [3:0]  win;       // priority winner
  logic        conflict, wp_any, first;
  logic [2:0]  ws_sel;
  logic [3:0]  target;
  logic        ack_int;

  // address, space code and enable comparison of one unit
  function automatic logic unit_hit(input logic [15:0] br, input logic [15:0] orr,
                                    input logic [23:13] a, input logic [2:0] fc);
    logic [10:0] diff;
    logic        fc_ok;
    diff  = (a ^ br[CSD_BR_ADDR_HI:CSD_BR_ADDR_LO]) & orr[CSD_OR_MASK_HI:CSD_OR_MASK_LO];
    fc_ok = !orr[CSD_OR_CFC] || (fc == br[CSD_BR_FC_HI:CSD_BR_FC_LO]);
    unit_hit = br[CSD_BR_EN] && (diff == 11'h000) && fc_ok
               && (br[CSD_BR_FC_HI:CSD_BR_FC_LO] != CSD_FC_RESERVED);
  endfunction : unit_hit

  assign strobe = !ADDRESS_STROBE_N;

  // register bus: one wait cycle, then the access completes
  assign req     = AVS_READ || AVS_WRITE;
  assign wr_take = AVS_WRITE && done_q;
  assign wmask   = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // matching of the current bus cycle
  always_comb begin
    for (int i = 0; i < CSD_UNITS; i++) begin
      hit[i] = unit_hit(base_q[i], opt_q[i], BUS_ADDR, SPACE_CODE)
               && (SPACE_CODE != CSD_FC_RESERVED)
               && !INT_ACK_CYCLE
               && !INTERNAL_ACCESS;
      // direction checked only with the check bit set
      full[i] = hit[i] && (!opt_q[i][CSD_OR_MRW] || (base_q[i][CSD_BR_RW] == BUS_WRITE));
      viol[i] = hit[i] && opt_q[i][CSD_OR_MRW] && !base_q[i][CSD_BR_RW] && BUS_WRITE;
    end
    win = 4'h0;
    if (full[0]) begin
      win = 4'h1;
    end else if (full[1]) begin
      win = 4'h2;
    end else if (full[2]) begin
      win = 4'h4;
    end else if (full[3]) begin
      win = 4'h8;
    end
    conflict = (full & (full - 4'h1)) != 4'h0;
    wp_any   = viol != 4'h0;
    first    = strobe && !strobe_q;
  end

  // wait-state acknowledge of the winning unit
  always_comb begin
    ws_sel = CSD_WS_EXTERNAL;
    for (int i = 0; i < CSD_UNITS; i++) begin
      if (win[i]) begin
        ws_sel = opt_q[i][CSD_OR_WS_HI:CSD_OR_WS_LO];
      end
    end
    // the extra wait for external masters covers their slower decode path
    target  = {1'b0, ws_sel} + {3'h0, ctrl_q[CSD_CTRL_EXTERNAL_MASTER_EXTRA_WAIT] && EXTERNAL_MASTER};
    // zero waits and no external-master extra wait: counter is still 0, so acknowledge follows the match directly
    ack_int = strobe && (win != 4'h0) && (ws_sel != CSD_WS_EXTERNAL)
              && (cnt_q >= target);
  end

  // cycle counter and registered selects
  always_comb begin
    strobe_d = strobe;
    cnt_d    = 4'h0;
    sel_d    = 4'h0;
    if (strobe && (win != 4'h0)) begin
      // counted on MCLK whoever owns the bus
      cnt_d = (cnt_q == CSD_CNT_MAX) ? cnt_q : cnt_q + 4'h1;
      sel_d = win;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      strobe_q <= 1'b0;
      cnt_q    <= 4'h0;
      sel_q    <= 4'h0;
    end else begin
      strobe_q <= strobe_d;
      cnt_q    <= cnt_d;
      sel_q    <= sel_d;
    end
  end

  // selects gated by the strobe so they drop with it, not an edge later
  assign SELECT_N         = ~(sel_q & {4{strobe}});
  assign TRANSFER_ACK_N_O = 1'b0;
  assign TRANSFER_ACK_OE  = ack_int;
  assign BUS_ERROR_N_O    = 1'b0;
  assign BUS_ERROR_OE     = strobe && ((wp_any && ctrl_q[CSD_CTRL_WRITE_PROTECT_ERROR_ENABLE])
                                       || (conflict && ctrl_q[CSD_CTRL_DECODE_CONFLICT_ERROR_ENABLE]));

  // register file
  always_comb begin
    for (int i = 0; i < CSD_UNITS; i++) begin
      base_d[i] = base_q[i];
      opt_d[i]  = opt_q[i];
    end
    ctrl_d  = ctrl_q;
    stat_d  = stat_q;
    done_d  = req && !done_q;
    rdata_d = rdata_q;
    if (wr_take) begin
      // no disable needed first; the new value applies from the next cycle
      if (AVS_ADDRESS < CSD_IDX_OPT0) begin
        base_d[AVS_ADDRESS[1:0]] = (base_q[AVS_ADDRESS[1:0]] & ~wmask)
                                   | (AVS_WRITEDATA[15:0] & wmask);
      end else if (AVS_ADDRESS < CSD_IDX_CTRL) begin
        opt_d[AVS_ADDRESS[1:0]] = (opt_q[AVS_ADDRESS[1:0]] & ~wmask)
                                  | (AVS_WRITEDATA[15:0] & wmask);
      end else if (AVS_ADDRESS == CSD_IDX_CTRL) begin
        if (AVS_BYTEENABLE[0]) begin
          ctrl_d = AVS_WRITEDATA[2:0];
        end
      end else if (AVS_ADDRESS == CSD_IDX_STATUS) begin
        if (AVS_BYTEENABLE[0]) begin
          stat_d = stat_q & ~AVS_WRITEDATA[1:0];
        end
      end
    end
    // events set once per bus cycle; set wins over a clear in the same cycle
    if (first && wp_any) begin
      stat_d[CSD_STAT_WPV] = 1'b1;
    end
    if (first && conflict) begin
      stat_d[CSD_STAT_ADC] = 1'b1;
    end
    if (AVS_READ && !done_q) begin
      rdata_d = 32'h0;
      if (AVS_ADDRESS < CSD_IDX_OPT0) begin
        rdata_d = {16'h0, base_q[AVS_ADDRESS[1:0]]};
      end else if (AVS_ADDRESS < CSD_IDX_CTRL) begin
        rdata_d = {16'h0, opt_q[AVS_ADDRESS[1:0]]};
      end else if (AVS_ADDRESS == CSD_IDX_CTRL) begin
        rdata_d = {29'h0, ctrl_q};
      end else if (AVS_ADDRESS == CSD_IDX_STATUS) begin
        rdata_d = {30'h0, stat_q};
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < CSD_UNITS; i++) begin
        // only unit 0 comes up enabled
        base_q[i] <= (i == 0) ? CSD_BR0_RST : CSD_BRN_RST;
        opt_q[i]  <= CSD_OR_RST;
      end
      ctrl_q  <= CSD_CTRL_RST;
      stat_q  <= CSD_STAT_RST;
      done_q  <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      for (int i = 0; i < CSD_UNITS; i++) begin
        base_q[i] <= base_d[i];
        opt_q[i]  <= opt_d[i];
      end
      ctrl_q  <= ctrl_d;
      stat_q  <= stat_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign AVS_WAITREQUEST = req && !done_q;
  assign AVS_READDATA    = rdata_q;

endmodule : csd_top

// ===== csd_sva.sv
// csd_sva: port-level checks of the chip-select decoder
// assumes bus-cycle inputs change only just after MCLK rises
`timescale 1ns/10ps
module csd_sva (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       AVS_READ,
  input wire logic       AVS_WRITE,
  input wire logic       AVS_WAITREQUEST,
  input wire logic       ADDRESS_STROBE_N,
  input wire logic [2:0] SPACE_CODE,
  input wire logic       INTERNAL_ACCESS,
  input wire logic       INT_ACK_CYCLE,
  input wire logic [3:0] SELECT_N,
  input wire logic       TRANSFER_ACK_OE,
  input wire logic       BUS_ERROR_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sel_onehot_a: assert property ($onehot0(~SELECT_N)) else $error("two selects");
  sel_idle_a: assert property (ADDRESS_STROBE_N |-> SELECT_N == 4'hf)
    else $error("select without strobe");
  fc_block_a: assert property (!ADDRESS_STROBE_N && SPACE_CODE == 3'h7
    |-> SELECT_N == 4'hf && !TRANSFER_ACK_OE) else $error("space code 7 selected");
  int_block_a: assert property (INTERNAL_ACCESS |-> SELECT_N == 4'hf && !BUS_ERROR_OE)
    else $error("internal access selected");
  iack_block_a: assert property (INT_ACK_CYCLE |-> SELECT_N == 4'hf)
    else $error("int ack selected");
  ack_idle_a: assert property (ADDRESS_STROBE_N |-> !TRANSFER_ACK_OE && !BUS_ERROR_OE)
    else $error("ack without strobe");
  ack_hold_a: assert property (TRANSFER_ACK_OE ##1 !ADDRESS_STROBE_N |-> TRANSFER_ACK_OE)
    else $error("ack dropped early");
  // a register write may legally move the select, so it is excluded
  sel_steady_a: assert property (!ADDRESS_STROBE_N[*3] ##0 !$past(AVS_WRITE)
    |-> $stable(SELECT_N)) else $error("select moved in cycle");
  reg_wait_a: assert property ($rose(AVS_READ | AVS_WRITE)
    |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("register wait wrong");
  cover property (TRANSFER_ACK_OE);
  cover property (BUS_ERROR_OE);
  cover property (!SELECT_N[3]);
endmodule : csd_sva

// ===== csd_master.sv
// csd_master: bus master and memory side, one strobed cycle at a time
// assumes it is entered just after MCLK rises; the memories never drive acknowledge
`timescale 1ns/10ps
module csd_master (
  input  wire logic [3:0] sel_n,
  input  wire logic       clk,
  input  wire logic       ack_oe,
  input  wire logic       bus_error_signal_oe,
  output logic            as_n,
  output logic [23:13]    addr,
  output logic [2:0]      fc,
  output logic            wr,
  output logic            ia,
  output logic            iack,
  output logic            em
);
  int         ack_at;
  logic [3:0] sel_seen;
  logic       bus_error_signal_seen;
  initial {as_n, addr, fc, wr, ia, iack, em} = {1'b1, 18'h0};
  // acknowledge is left to the decoder for every block
  task automatic run(input logic [23:13] a, input logic [2:0] f, input logic [3:0] k);
    as_n <= 1'b0;
    addr <= a;
    fc <= f;
    {wr, ia, iack, em} <= k;
    ack_at = 0;
    sel_seen = 4'h0;
    bus_error_signal_seen = 1'b0;
    for (int c = 1; c <= 10; c++) begin
      @(negedge clk);
      if (ack_oe === 1'b1 && ack_at == 0) ack_at = c;
      if (c > 1) sel_seen = sel_seen | ~sel_n;
      bus_error_signal_seen = bus_error_signal_seen | bus_error_signal_oe;
      @(posedge clk);
    end
    // no pull on these lines, so a released bus shows the inverse, not a stale value
    as_n <= 1'b1;
    addr <= ~a;
    fc <= ~f;
    @(posedge clk);
  endtask : run
endmodule : csd_master

// ===== tb.sv
// tb: reset values, wait-state sweep and random decode cycles against a reference
// assumes csd_master drives the processor bus, the bench the register bus
`timescale 1ns/10ps
module tb;
  import csd_pkg::*;
  logic MCLK, RST, rd, wrq, wreq, as_n, wr, ia, iack, em, ack_oe, ack_o, bus_error_signal_oe, bus_error_signal_o;
  logic [3:0]   adr, sel_n;
  logic [31:0]  wd, rdat, seed, q;
  logic [23:13] a;
  logic [2:0]   fc, ctl;
  logic [15:0]  br [4];
  logic [15:0]  op [4];
  logic [1:0]   u;
  int           n_mismatch, tests_run, cyc;
  csd_top DUT (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wrq),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .ADDRESS_STROBE_N(as_n), .BUS_ADDR(a), .SPACE_CODE(fc), .BUS_WRITE(wr),
    .INTERNAL_ACCESS(ia), .INT_ACK_CYCLE(iack), .EXTERNAL_MASTER(em), .SELECT_N(sel_n),
    .TRANSFER_ACK_N_O(ack_o), .TRANSFER_ACK_OE(ack_oe), .BUS_ERROR_N_O(bus_error_signal_o),
    .BUS_ERROR_OE(bus_error_signal_oe));
  csd_master m (.clk(MCLK), .sel_n(sel_n), .ack_oe(ack_oe), .bus_error_signal_oe(bus_error_signal_oe), .as_n(as_n),
    .addr(a), .fc(fc), .wr(wr), .ia(ia), .iack(iack), .em(em));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic reg_op(input logic w, input logic [3:0] i, input logic [15:0] d);
    adr <= i;
    wrq <= w;
    rd <= !w;
    wd <= {16'h0, d};
    @(posedge MCLK);
    while (wreq !== 1'b0) @(posedge MCLK);
    q = rdat;
    wrq <= 1'b0;
    rd <= 1'b0;
    if (w && i < 4) br[i[1:0]] = d;
    else if (w && i < 8) op[i[1:0]] = d;
    else if (w && i == CSD_IDX_CTRL) ctl = d[2:0];
    @(posedge MCLK);
  endtask : reg_op
  // k = {write, internal, int ack, external master}; result {conflict, wp, bus_error_signal, ack, sel}
  function automatic logic [10:0] exp_cyc(input logic [23:13] x, input logic [2:0] f,
                                          input logic [3:0] k);
    logic [3:0] hit, wp;
    logic [2:0] w;
    logic       pre, adc;
    w = 3'h7;
    for (int j = 3; j >= 0; j--) begin
      pre = br[j][0] && br[j][15:13] != 3'h7 && f != 3'h7 && !k[2] && !k[1]
        && ((x ^ br[j][12:2]) & op[j][12:2]) == 11'h0 && (!op[j][0] || f == br[j][15:13]);
      hit[j] = pre && (!op[j][1] || k[3] == br[j][1]);
      wp[j] = pre && op[j][1] && !br[j][1] && k[3];
      if (hit[j]) w = op[j][15:13];
    end
    adc = (hit & (hit - 4'h1)) != 4'h0;
    return {adc, |wp, (|wp & ctl[0]) | (adc & ctl[1]),
      (w == 3'h7) ? 4'h0 : {1'b0, w} + 4'h1 + {3'h0, ctl[2] & k[0]}, hit & (~hit + 4'h1)};
  endfunction : exp_cyc
  task automatic cyc_chk(input logic [23:13] x, input logic [2:0] f, input logic [3:0] k);
    logic [10:0] e;
    e = exp_cyc(x, f, k);
    m.run(x, f, k);
    check(m.sel_seen, e[3:0]);
    check(m.ack_at, e[7:4]);
    check(m.bus_error_signal_seen, e[8]);
    check({ack_o, bus_error_signal_o}, 32'h0);
    reg_op(1'b0, CSD_IDX_STATUS, 16'h0);
    check(q, e[10:9]);
    reg_op(1'b1, CSD_IDX_STATUS, 16'h3);
  endtask : cyc_chk
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    {RST, adr, rd, wrq, wd, n_mismatch, tests_run, cyc} = {1'b1, 38'h0, 64'h0, 32'h0};
    seed = 32'h0552e9b6;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    for (int j = 0; j < 8; j++) begin
      reg_op(1'b0, j[3:0], 16'h0);
      check(q, j < 4 ? {16'h0, 3'h6, 12'h0, j == 0} : {16'h0, 3'h6, 11'h7ff, 2'b01});
    end
    {br[0], br[1], br[2], br[3]} = {16'hc001, {3{16'hc000}}};
    {op[0], op[1], op[2], op[3], ctl} = {{4{16'hdffd}}, 3'h0};
    cyc_chk(11'h0, 3'h6, 4'h0);
    cyc_chk(11'h0, 3'h5, 4'h0);
    $display("reset test done");
    reg_op(1'b1, CSD_IDX_CTRL, 16'h4);
    // waits change while unit 0 stays enabled
    for (int w = 0; w < 8; w++) begin
      reg_op(1'b1, CSD_IDX_OPT0, {w[2:0], 11'h7ff, 2'b00});
      cyc_chk(11'h0, 3'h2, {3'b100, w[0]});
    end
    $display("wait test done");
    for (int j = 1; j < 4; j++) begin
      seed = nx(seed);
      reg_op(1'b1, 4'h4 + j[3:0], seed[15:0]);
      reg_op(1'b1, j[3:0], {seed[31:29], seed[12:2] & seed[28:18], seed[1], 1'b1});
    end
    for (int i = 0; i < 300; i++) begin
      seed = nx(seed);
      if (seed[3:0] == 4'h0) reg_op(1'b1, {1'b0, seed[6:4]}, seed[31:16]);
      else if (seed[3:0] == 4'h1) reg_op(1'b1, CSD_IDX_CTRL, {13'h0, seed[18:16]});
      seed = nx(seed);
      u = seed[1:0];
      cyc_chk(br[u][12:2] ^ (seed[12:2] & ~op[u][12:2]) ^ (seed[24] ? seed[23:13] : 11'h0),
        seed[28] ? br[u][15:13] : seed[27:25],
        {seed[29], seed[9:8] == 2'b11, seed[11:10] == 2'b11, seed[30]});
    end
    $display("random test done");
    give_verdict();
  end
endmodule : tb
bind csd_top csd_sva u_sva (.MCLK(MCLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .ADDRESS_STROBE_N(ADDRESS_STROBE_N),
  .SPACE_CODE(SPACE_CODE), .INTERNAL_ACCESS(INTERNAL_ACCESS), .INT_ACK_CYCLE(INT_ACK_CYCLE),
  .SELECT_N(SELECT_N), .TRANSFER_ACK_OE(TRANSFER_ACK_OE), .BUS_ERROR_OE(BUS_ERROR_OE));
